// >>> src/lsa_pkg.sv
package lsa_pkg;
	// Object counts per latch type and client sessions (panel is session 0)
	localparam int NLED = 8;
	localparam int NBO = 4;
	localparam int NSC = 4;
	localparam int NSES = 3;
	localparam int SESW = 2;
	localparam int LVLW = 3;
	localparam int AW = 8;
	// Register offsets
	localparam logic [AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [AW-1:0] OFS_CFG = 8'h04;
	localparam logic [AW-1:0] OFS_AUTO = 8'h08;
	localparam logic [AW-1:0] OFS_COLL = 8'h0C;
	localparam logic [AW-1:0] OFS_STATE = 8'h10;
	localparam logic [AW-1:0] OFS_IRQST = 8'h14;
	localparam logic [AW-1:0] OFS_IRQMSK = 8'h18;
	localparam logic [AW-1:0] OFS_OFFDLY = 8'h1C;
	localparam logic [AW-1:0] OFS_INACT = 8'h20;
	localparam logic [AW-1:0] OFS_LEVEL = 8'h24;
	// Field positions and reset values
	localparam int CTRL_REMOTE = 0;
	localparam int COLL_LED = 0;
	localparam int COLL_BO = 1;
	localparam int COLL_SC = 2;
	localparam int COLL_TRIP = 3;
	localparam int IRQ_LATCH = 0;
	localparam int IRQ_CLEAR = 1;
	localparam int IRQ_EXPIRE = 2;
	localparam int IRQW = 3;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam logic [LVLW-1:0] READ_ONLY_LEVEL = 3'h0;
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int BOOT_HOLD_MS = 100;
	localparam int BOOT_HOLD_CYC = BOOT_HOLD_MS * (CLK_HZ / 1000);
	localparam int BOOT_SETTLE = 4;
	localparam int INACT_S = 20;
	localparam longint INACT_CYC = longint'(INACT_S) * CLK_HZ;
	// Reset menu policy and boot states
	typedef enum logic [1:0] {POL_BOTH, POL_FACT_ONLY, POL_OFF} lsa_pol_t;
	typedef enum logic [1:0] {ST_BOOT, ST_MENU, ST_RUN} lsa_boot_t;
	// One bit per latchable object
	typedef struct packed {
		logic [NLED-1:0] led;
		logic [NBO-1:0] bo;
		logic [NSC-1:0] sc;
		logic trip;
	} lsa_vec_t;
	// Grouped acknowledge inputs
	typedef struct packed {
		logic led;
		logic bo;
		logic sc;
	} lsa_grp_t;
endpackage

// >>> src/lsa_sync.sv
`timescale 1ns/10ps
module lsa_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk, // Device clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic [W-1:0] din, // Asynchronous pins
	output logic [W-1:0] dout, // Synchronised levels
	output logic [W-1:0] rise // One-cycle rising edges
);
	logic [W-1:0] meta;
	logic [W-1:0] prev;

	// Two-flop synchroniser, then edge history
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta <= '0;
			dout <= '0;
			prev <= '0;
		end else begin
			meta <= din;
			dout <= meta;
			prev <= dout;
		end
	end

	// Edge detect on the settled level only
	assign rise = dout & ~prev;
endmodule // lsa_sync

// >>> src/lsa_offdelay.sv
`timescale 1ns/10ps
module lsa_offdelay #(
	parameter int CW = 16
) (
	input wire logic sys_clk, // Device clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic din, // Relay demand
	input wire logic [CW-1:0] dly, // Off-delay in cycles
	output logic dout // Relay drive
);
	logic [CW-1:0] cnt;

	// Pull in at once, drop out after dly cycles
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			dout <= 1'b0;
			cnt <= '0;
		end else if (din) begin
			dout <= 1'b1;
			cnt <= '0;
		end else if (dout) begin
			if (cnt + 1'b1 >= dly) begin
				dout <= 1'b0;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end

	a_off_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(din) && dly > 2 |=> dout ##1 dout)
		else $error("relay dropped before off-delay");
	a_off_end: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!din && dout && cnt + 1'b1 >= dly |=> !dout)
		else $error("relay held past off-delay");
endmodule // lsa_offdelay

// >>> src/lsa_top.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
// Overview of operation
// - latching enabled per LED, relay, SCADA, trip
// - individual signal clears its one latch
// - group signal clears all latches of group
// - alarm clears LEDs set for auto-clear
// - alarm never clears relays, SCADA or trip
// - collective commands each clear their set
// - panel cancel key clears all latches
// - latch clears only once its source dropped
// - remote disabled leaves only cancel key working
// - released relay drops after off-delay elapses
// - unlocked level permits that level and below
// - each session holds its own unlock
// - idle session falls back to read-only
// - policy: both, factory only, or menu off
// - factory reset clears settings, then restarts
// - password reset restores default passwords
module lsa_top #(
	parameter int HOLD_CYC = lsa_pkg::BOOT_HOLD_CYC,
	parameter logic [31:0] INACT_DEF = 32'(lsa_pkg::INACT_CYC),
	parameter logic [15:0] OFFDLY_DEF = 16'h0028
) (
	input wire logic sys_clk, // 40 MHz device clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [lsa_pkg::AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped
	input wire lsa_pkg::lsa_vec_t srcPin, // Signals that set latches
	input wire lsa_pkg::lsa_vec_t indAckPin, // Individual acknowledges
	input wire lsa_pkg::lsa_grp_t grpAckPin, // Grouped acknowledges
	input wire logic protAlarmPin, // New protection alarm
	input wire logic genAlarmPin, // General protection alarm
	input wire logic cancelKeyPin, // Panel cancel key
	input wire lsa_pkg::lsa_pol_t resetPolicy, // Stored reset menu policy
	input wire logic factoryConfirm, // Factory reset confirmed
	input wire logic pwConfirm, // Password reset confirmed
	input wire logic unlockValid, // Password accepted pulse
	input wire logic [lsa_pkg::SESW-1:0] unlockSes, // Session of unlock
	input wire logic [lsa_pkg::LVLW-1:0] unlockLevel, // Level unlocked
	input wire logic [lsa_pkg::NSES-1:0] lockReq, // Return to read-only
	input wire logic [lsa_pkg::NSES-1:0] keyAct, // Key activity per session
	input wire logic [lsa_pkg::SESW-1:0] qSes, // Permission query session
	input wire logic [lsa_pkg::LVLW-1:0] qLevel, // Level needed by action
	output logic permit, // Action permitted
	output lsa_pkg::lsa_vec_t indOut, // Indication drives
	output logic menuActive, // Reset menu shown
	output logic passwordRestoreOption, // Password reset offered
	output logic factoryReset, // Clear all but hours counter
	output logic restartReq, // Restart request
	output logic pwRestore, // Restore default passwords
	output logic irq // Level interrupt
);
	import lsa_pkg::*;

	localparam int VW = $bits(lsa_vec_t);
	localparam int GW = $bits(lsa_grp_t);
	localparam int SW = 2 * VW + GW + 3;

	logic [SW-1:0] pinSync;
	logic [SW-1:0] pinRise;
	lsa_vec_t srcS;
	lsa_vec_t indRise;
	lsa_grp_t grpRise;
	logic alarmRise;
	logic keyS;
	logic keyRise;
	logic ackKey;
	logic remoteEn;
	lsa_vec_t latchCfg;
	logic [NLED-1:0] ledAuto;
	logic [15:0] offDly;
	logic [31:0] inactCyc;
	logic [IRQW-1:0] irqSt;
	logic [IRQW-1:0] irqMsk;
	lsa_vec_t latched;
	lsa_vec_t remoteClr;
	lsa_vec_t clr;
	logic [3:0] coll;
	logic [NBO-1:0] boDrive;
	logic [IRQW-1:0] ev;
	logic wrEn;
	logic softClr;
	logic [LVLW-1:0] level [NSES];
	logic [31:0] idle [NSES];
	logic [NSES-1:0] expire;
	lsa_boot_t state;
	logic [31:0] holdCnt;

	function automatic logic regHit(input logic [AW-1:0] a);
		regHit = a == OFS_CTRL || a == OFS_CFG || a == OFS_AUTO || a == OFS_COLL
			|| a == OFS_STATE || a == OFS_IRQST || a == OFS_IRQMSK
			|| a == OFS_OFFDLY || a == OFS_INACT || a == OFS_LEVEL;
	endfunction

	// All pins pass the synchroniser before use
	lsa_sync #(.W(SW)) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.din({srcPin, indAckPin, grpAckPin, protAlarmPin, genAlarmPin, cancelKeyPin}),
		.dout(pinSync),
		.rise(pinRise)
	);

	// Split the synchronised bundle; acks act on edges
	assign srcS = lsa_vec_t'(pinSync[SW-1 -: VW]);
	assign indRise = lsa_vec_t'(pinRise[SW-VW-1 -: VW]);
	assign grpRise = lsa_grp_t'(pinRise[3 +: GW]);
	assign alarmRise = pinRise[2] | pinRise[1];
	assign keyS = pinSync[0];
	assign keyRise = pinRise[0];
	assign ackKey = keyRise && state == ST_RUN;

	// APB slave: zero wait states
	assign pready = 1'b1;
	assign pslverr = psel && penable && !regHit(paddr);
	assign wrEn = psel && penable && pwrite && regHit(paddr);
	assign softClr = sys_rst || factoryReset;

	// Configuration registers
	always_ff @(posedge sys_clk) begin
		if (softClr) begin
			remoteEn <= CTRL_RST[CTRL_REMOTE];
			latchCfg <= '0;
			ledAuto <= '0;
			offDly <= OFFDLY_DEF;
			inactCyc <= INACT_DEF;
			irqMsk <= '0;
		end else if (wrEn) begin
			case (paddr)
				OFS_CTRL: remoteEn <= pwdata[CTRL_REMOTE];
				OFS_CFG: latchCfg <= lsa_vec_t'(pwdata[VW-1:0]);
				OFS_AUTO: ledAuto <= pwdata[NLED-1:0];
				OFS_OFFDLY: offDly <= pwdata[15:0];
				OFS_INACT: inactCyc <= pwdata;
				OFS_IRQMSK: irqMsk <= pwdata[IRQW-1:0];
				default: ;
			endcase
		end
	end

	// Collective command pulses, one cycle per write
	always_ff @(posedge sys_clk) begin
		if (softClr) begin
			coll <= '0;
		end else begin
			coll <= (wrEn && paddr == OFS_COLL) ? pwdata[3:0] : 4'h0;
		end
	end

	// Read data taken in the setup phase
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFS_CTRL: prdata <= 32'({remoteEn});
				OFS_CFG: prdata <= 32'(latchCfg);
				OFS_AUTO: prdata <= 32'(ledAuto);
				OFS_STATE: prdata <= 32'(latched);
				OFS_IRQST: prdata <= 32'(irqSt);
				OFS_IRQMSK: prdata <= 32'(irqMsk);
				OFS_OFFDLY: prdata <= 32'(offDly);
				OFS_INACT: prdata <= inactCyc;
				OFS_LEVEL: prdata <= 32'({level[2], level[1], level[0]});
				default: prdata <= '0;
			endcase
		end
	end

	// Acknowledge requests gathered per object
	always_comb begin
		remoteClr = indRise;
		if (grpRise.led || coll[COLL_LED]) begin
			remoteClr.led = '1;
		end
		if (grpRise.bo || coll[COLL_BO]) begin
			remoteClr.bo = '1;
		end
		if (grpRise.sc || coll[COLL_SC]) begin
			remoteClr.sc = '1;
		end
		if (coll[COLL_TRIP]) begin
			remoteClr.trip = 1'b1;
		end
		remoteClr.led = remoteClr.led | (ledAuto & {NLED{alarmRise}});
		clr = remoteEn ? remoteClr : '0;
		if (ackKey) begin
			clr = '1;
		end
	end

	// Latches hold while the source stands
	always_ff @(posedge sys_clk) begin
		if (softClr) begin
			latched <= '0;
		end else begin
			latched <= lsa_vec_t'(latchCfg & (srcS | (latched & ~clr)));
		end
	end

	// Relay off-delay per binary output
	generate
		for (genvar b = 0; b < NBO; b++) begin : g_bo
			lsa_offdelay #(.CW(16)) u_off (
				.sys_clk(sys_clk),
				.sys_rst(softClr),
				.din(srcS.bo[b] | latched.bo[b]),
				.dly(offDly),
				.dout(boDrive[b])
			);
		end
	endgenerate

	// Indication outputs
	always_ff @(posedge sys_clk) begin
		if (softClr) begin
			indOut <= '0;
		end else begin
			indOut.led <= srcS.led | latched.led;
			indOut.bo <= boDrive;
			indOut.sc <= srcS.sc | latched.sc;
			indOut.trip <= srcS.trip | latched.trip;
		end
	end

	// Sticky status, set wins over clear
	assign ev[IRQ_LATCH] = |(latchCfg & srcS & ~latched);
	assign ev[IRQ_CLEAR] = |(latched & clr & ~srcS);
	assign ev[IRQ_EXPIRE] = |expire;
	always_ff @(posedge sys_clk) begin
		if (softClr) begin
			irqSt <= '0;
		end else begin
			irqSt <= (irqSt & ~((wrEn && paddr == OFS_IRQST) ? pwdata[IRQW-1:0] : '0)) | ev;
		end
	end
	assign irq = |(irqSt & irqMsk);

	// Per-session access level and inactivity timer
	generate
		for (genvar s = 0; s < NSES; s++) begin : g_ses
			assign expire[s] = level[s] != READ_ONLY_LEVEL && idle[s] + 1'b1 >= inactCyc
				&& !keyAct[s] && !(unlockValid && unlockSes == SESW'(s)) && !lockReq[s];
			always_ff @(posedge sys_clk) begin
				if (softClr) begin
					level[s] <= READ_ONLY_LEVEL;
					idle[s] <= '0;
				end else if (unlockValid && unlockSes == SESW'(s)) begin
					level[s] <= unlockLevel;
					idle[s] <= '0;
				end else if (lockReq[s]) begin
					level[s] <= READ_ONLY_LEVEL;
					idle[s] <= '0;
				end else if (keyAct[s] || level[s] == READ_ONLY_LEVEL) begin
					idle[s] <= '0;
				end else if (expire[s]) begin
					level[s] <= READ_ONLY_LEVEL;
					idle[s] <= '0;
				end else begin
					idle[s] <= idle[s] + 1'b1;
				end
			end
		end
	endgenerate

	// Permission check against the querying session
	always_ff @(posedge sys_clk) begin
		if (softClr) begin
			permit <= 1'b0;
		end else begin
			permit <= qSes < SESW'(NSES) && level[qSes] >= qLevel;
		end
	end

	// Boot sequence and reset menu
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= ST_BOOT;
			holdCnt <= '0;
		end else begin
			case (state)
				ST_BOOT: begin
					holdCnt <= holdCnt + 1'b1;
					if (holdCnt + 1'b1 >= 32'(HOLD_CYC)) begin
						state <= (keyS && resetPolicy != POL_OFF) ? ST_MENU : ST_RUN;
					end else if (!keyS && holdCnt >= 32'(BOOT_SETTLE)) begin
						state <= ST_RUN;
					end
				end
				ST_MENU: begin
					holdCnt <= '0;
					if (factoryConfirm) begin
						state <= ST_BOOT;
					end else if (pwConfirm && resetPolicy == POL_BOTH) begin
						state <= ST_RUN;
					end else if (keyRise) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: holdCnt <= '0;
				default: state <= ST_BOOT;
			endcase
		end
	end

	// Reset menu action pulses
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			factoryReset <= 1'b0;
			restartReq <= 1'b0;
			pwRestore <= 1'b0;
		end else begin
			factoryReset <= state == ST_MENU && factoryConfirm;
			restartReq <= state == ST_MENU && factoryConfirm;
			pwRestore <= state == ST_MENU && !factoryConfirm && pwConfirm
				&& resetPolicy == POL_BOTH;
		end
	end
	assign menuActive = state == ST_MENU;
	assign passwordRestoreOption = state == ST_MENU && resetPolicy == POL_BOTH;

	a_cfg_gates_latch: assert property (@(posedge sys_clk) disable iff (softClr)
		!latchCfg.led[0] && !wrEn |=> !latched.led[0])
		else $error("LED latched while latching disabled");
	a_ind_clear_one: assert property (@(posedge sys_clk) disable iff (softClr)
		remoteEn && indRise.led[0] && latchCfg.led[0] && !srcS.led[0] && !wrEn |=> !latched.led[0])
		else $error("individual acknowledge missed");
	a_group_led_clear: assert property (@(posedge sys_clk) disable iff (softClr)
		remoteEn && grpRise.led && srcS.led == '0 |=> latched.led == '0)
		else $error("group acknowledge left LED latched");
	a_auto_led_clear: assert property (@(posedge sys_clk) disable iff (softClr)
		remoteEn && alarmRise && ledAuto[0] && !srcS.led[0] |=> !latched.led[0])
		else $error("auto acknowledge missed");
	a_auto_not_bo: assert property (@(posedge sys_clk) disable iff (softClr)
		alarmRise && !ackKey && !grpRise.bo && !coll[COLL_BO] && indRise.bo == '0
		&& latched.bo[0] && latchCfg.bo[0] && !wrEn |=> latched.bo[0])
		else $error("alarm cleared a relay latch");
	a_coll_trip: assert property (@(posedge sys_clk) disable iff (softClr)
		remoteEn && coll[COLL_TRIP] && !srcS.trip |=> !latched.trip)
		else $error("collective command missed trip");
	a_key_clears: assert property (@(posedge sys_clk) disable iff (softClr)
		ackKey && srcS.sc == '0 |=> latched.sc == '0)
		else $error("cancel key left SCADA latched");
	a_src_holds: assert property (@(posedge sys_clk) disable iff (softClr)
		srcS.led[1] && latchCfg.led[1] && !wrEn |=> latched.led[1])
		else $error("latch cleared with source active");
	a_remote_block: assert property (@(posedge sys_clk) disable iff (softClr)
		!remoteEn && !ackKey && latched.sc[0] && latchCfg.sc[0] && !wrEn |=> latched.sc[0])
		else $error("acknowledge passed with remote disabled");
	a_edge_once: assert property (@(posedge sys_clk) disable iff (softClr)
		indRise.led[2] |=> !indRise.led[2])
		else $error("acknowledge edge repeated");
	a_permit_level: assert property (@(posedge sys_clk) disable iff (softClr)
		qSes == '0 && qLevel <= level[0] |=> permit)
		else $error("permission refused at unlocked level");
	a_unlock_own: assert property (@(posedge sys_clk) disable iff (softClr)
		unlockValid && unlockSes == 2'h1 && !lockReq[0] && !keyAct[0] && !expire[0]
		|=> level[0] == $past(level[0]))
		else $error("unlock leaked into panel session");
	a_idle_expire: assert property (@(posedge sys_clk) disable iff (softClr)
		expire[1] |=> level[1] == READ_ONLY_LEVEL)
		else $error("idle session kept its level");
	a_policy_menu: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state == ST_MENU |-> resetPolicy != POL_OFF || $past(state) == ST_MENU)
		else $error("menu entered while disabled");
	a_factory_restart: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state == ST_MENU && factoryConfirm |=> factoryReset && restartReq ##1 latched == '0)
		else $error("factory reset incomplete");
	a_pw_policy: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pwRestore |-> $past(resetPolicy) == POL_BOTH && $past(state) == ST_MENU)
		else $error("password reset outside policy");

	c_key_ack: cover property (@(posedge sys_clk) disable iff (softClr) ackKey && latched != '0);
	c_auto_ack: cover property (@(posedge sys_clk) disable iff (softClr) alarmRise && (latched.led & ledAuto) != '0);
	c_expire: cover property (@(posedge sys_clk) disable iff (softClr) expire != '0);
	c_menu: cover property (@(posedge sys_clk) disable iff (sys_rst) state == ST_MENU);
endmodule // lsa_top

// >>> dv/lsa_panel_model.sv
`timescale 1ns/10ps
// Operator panel: holds the cancel key through a cold start and presses it on request
module lsa_panel_model #(
	parameter int GIVEUP = 60
) (
	input wire logic sys_clk, // Device clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic bootHold, // Hold key through cold start
	input wire logic pressReq, // Start one short press
	input wire logic menuActive, // Reset menu shown
	output logic cancelKeyPin // Cancel key, high when pressed
);
	logic booting;
	logic [7:0] holdCnt;
	logic [2:0] pressCnt;
	// Key stays down from reset until the menu shows, or the operator gives up
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			booting <= bootHold;
			holdCnt <= 8'h00;
		end else if (booting) begin
			holdCnt <= holdCnt + 8'h01;
			if (menuActive || holdCnt == 8'(GIVEUP)) begin
				booting <= 1'h0;
			end
		end
	end
	// Short press lasting four cycles
	always_ff @(posedge sys_clk) begin
		if (sys_rst || pressReq) begin
			pressCnt <= sys_rst ? 3'h0 : 3'h4;
		end else if (pressCnt != 3'h0) begin
			pressCnt <= pressCnt - 3'h1;
		end
	end
	// Key level seen by the block
	assign cancelKeyPin = booting || pressCnt != 3'h0;
endmodule // lsa_panel_model

// >>> dv/test_latched_state_acknowledge.sv
`timescale 1ns/10ps
module test_latched_state_acknowledge;
	import lsa_pkg::*;
	localparam int OD = 30;
	localparam logic [31:0] M_ALL = 32'h0001_FFFF;
	logic [31:0] masks [4] = '{32'h0001_FE00, 32'h0000_01E0, 32'h0000_001E, 32'h0000_0001};
	logic sys_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
	logic [AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	lsa_vec_t srcPin = '0, indAckPin = '0, indOut;
	lsa_grp_t grpAckPin = '0;
	lsa_pol_t resetPolicy = POL_BOTH;
	logic protAlarmPin = 1'h0, genAlarmPin = 1'h0, cancelKeyPin, bootHold = 1'h0, pressReq = 1'h0;
	logic factoryConfirm = 1'h0, pwConfirm = 1'h0, unlockValid = 1'h0, permit;
	logic [SESW-1:0] unlockSes = '0, qSes = '0;
	logic [LVLW-1:0] unlockLevel = '0, qLevel = '0;
	logic [NSES-1:0] lockReq = '0, keyAct = '0;
	logic menuActive, passwordRestoreOption, factoryReset, restartReq, pwRestore, irq;
	int numErrors = 0;
	int nChecks = 0;

	// Clock at 40 MHz
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	lsa_top #(.HOLD_CYC(20), .INACT_DEF(32'h0000_0032)) dut_u (
		.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.srcPin, .indAckPin, .grpAckPin, .protAlarmPin, .genAlarmPin, .cancelKeyPin, .resetPolicy,
		.factoryConfirm, .pwConfirm, .unlockValid, .unlockSes, .unlockLevel, .lockReq, .keyAct,
		.qSes, .qLevel, .permit, .indOut, .menuActive, .passwordRestoreOption, .factoryReset,
		.restartReq, .pwRestore, .irq
	);

	lsa_panel_model #(.GIVEUP(60)) pnl_u (
		.sys_clk, .sys_rst, .bootHold, .pressReq, .menuActive, .cancelKeyPin
	);

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic endSim;
		$display("checks %0d errors %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Word and bit comparisons
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		nChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp, input string msg);
		chk({31'h0, got}, {31'h0, exp}, msg);
	endtask

	// One APB transfer; waits for pready, then releases after that edge
	task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask

	task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] exp, input string msg);
		apb(1'h0, a, 32'h0000_0000);
		chk(rd, exp, msg);
	endtask

	// Pulses source pins (sel 0) or individual acknowledges (sel 1)
	task automatic pulse_vec(input logic sel, input logic [31:0] v);
		if (sel) begin
			indAckPin <= lsa_vec_t'(v[16:0]);
		end else begin
			srcPin <= lsa_vec_t'(v[16:0]);
		end
		tick(4);
		if (sel) begin
			indAckPin <= '0;
		end else begin
			srcPin <= '0;
		end
		tick(4);
	endtask

	task automatic t_regs;
		rd_chk(OFS_CTRL, CTRL_RST, "ctrl reset");
		rd_chk(OFS_OFFDLY, 32'h0000_0028, "offdly reset");
		rd_chk(OFS_INACT, 32'h0000_0032, "inact reset");
		rd_chk(OFS_LEVEL, 32'h0000_0000, "level reset");
		apb(1'h1, 8'h40, 32'hFFFF_FFFF);
		chkb(err, 1'h1, "unmapped write");
		rd_chk(8'h40, 32'h0000_0000, "unmapped read");
		chkb(err, 1'h1, "unmapped read err");
		apb(1'h1, OFS_CFG, M_ALL);
		rd_chk(OFS_CFG, M_ALL, "cfg");
		apb(1'h1, OFS_OFFDLY, 32'(OD));
	endtask

	task automatic t_ind;
		pulse_vec(1'h0, 32'h0000_0602);
		chk(32'(indOut), 32'h0000_0602, "held");
		pulse_vec(1'h1, 32'h0000_0200);
		rd_chk(OFS_STATE, 32'h0000_0402, "single ack");
		srcPin.trip <= 1'h1;
		tick(6);
		pulse_vec(1'h1, 32'h0000_0001);
		srcPin.trip <= 1'h0;
		tick(6);
		rd_chk(OFS_STATE, 32'h0000_0403, "source active");
		indAckPin.trip <= 1'h1;
		tick(6);
		rd_chk(OFS_STATE, 32'h0000_0402, "source dropped");
		pulse_vec(1'h0, 32'h0000_0001);
		rd_chk(OFS_STATE, 32'h0000_0403, "ack held");
		indAckPin.trip <= 1'h0;
		tick(4);
	endtask

	task automatic t_grp_coll;
		logic [31:0] exp;
		pulse_vec(1'h0, M_ALL);
		exp = M_ALL;
		for (int i = 0; i < 3; i++) begin
			grpAckPin <= lsa_grp_t'(3'h4 >> i);
			tick(4);
			grpAckPin <= '0;
			tick(4);
			exp = exp & ~masks[i];
			rd_chk(OFS_STATE, exp, "group ack");
		end
		for (int i = 0; i < 4; i++) begin
			pulse_vec(1'h0, M_ALL);
			apb(1'h1, OFS_COLL, 32'h0000_0001 << i);
			tick(2);
			rd_chk(OFS_STATE, M_ALL & ~masks[i], "collective");
		end
		apb(1'h1, OFS_COLL, 32'h0000_000F);
		tick(2);
		rd_chk(OFS_STATE, 32'h0000_0000, "collective all");
		rd_chk(OFS_COLL, 32'h0000_0000, "coll reads 0");
	endtask

	task automatic t_auto;
		apb(1'h1, OFS_AUTO, 32'h0000_0001);
		pulse_vec(1'h0, 32'h0000_0623);
		protAlarmPin <= 1'h1;
		tick(4);
		protAlarmPin <= 1'h0;
		tick(4);
		rd_chk(OFS_STATE, 32'h0000_0423, "prot alarm");
		pulse_vec(1'h0, 32'h0000_0200);
		genAlarmPin <= 1'h1;
		tick(4);
		genAlarmPin <= 1'h0;
		tick(4);
		rd_chk(OFS_STATE, 32'h0000_0423, "gen alarm");
	endtask

	task automatic t_remote;
		apb(1'h1, OFS_CTRL, 32'h0000_0000);
		pulse_vec(1'h0, M_ALL);
		apb(1'h1, OFS_COLL, 32'h0000_000F);
		pulse_vec(1'h1, M_ALL);
		grpAckPin <= lsa_grp_t'(3'h7);
		tick(4);
		grpAckPin <= '0;
		tick(4);
		rd_chk(OFS_STATE, M_ALL, "remote off");
		pressReq <= 1'h1;
		tick(1);
		pressReq <= 1'h0;
		tick(10);
		rd_chk(OFS_STATE, 32'h0000_0000, "cancel key");
		apb(1'h1, OFS_CTRL, 32'h0000_0001);
	endtask

	task automatic t_offdly;
		int n;
		pulse_vec(1'h0, 32'h0000_0020);
		chkb(indOut.bo[0], 1'h1, "relay held");
		indAckPin.bo[0] <= 1'h1;
		for (n = 0; n < 200 && indOut.bo[0] !== 1'h0; n++) begin
			tick(1);
		end
		chkb(n >= OD && n <= OD + 8, 1'h1, "off delay");
		indAckPin.bo[0] <= 1'h0;
		tick(4);
	endtask

	task automatic t_ses;
		apb(1'h1, OFS_IRQST, 32'h0000_0007);
		apb(1'h1, OFS_IRQMSK, 32'h0000_0004);
		chkb(irq, 1'h0, "irq idle");
		unlockSes <= 2'h1;
		unlockLevel <= 3'h3;
		unlockValid <= 1'h1;
		tick(1);
		unlockValid <= 1'h0;
		qSes <= 2'h1;
		qLevel <= 3'h2;
		tick(2);
		chkb(permit, 1'h1, "lower level");
		qLevel <= 3'h4;
		tick(2);
		chkb(permit, 1'h0, "higher level");
		qSes <= 2'h0;
		qLevel <= 3'h1;
		tick(2);
		chkb(permit, 1'h0, "other session");
		rd_chk(OFS_LEVEL, 32'h0000_0018, "level map");
		repeat (4) begin
			keyAct <= 3'h2;
			tick(1);
			keyAct <= 3'h0;
			tick(20);
		end
		rd_chk(OFS_LEVEL, 32'h0000_0018, "kept alive");
		tick(70);
		rd_chk(OFS_LEVEL, 32'(READ_ONLY_LEVEL), "expired");
		chkb(irq, 1'h1, "irq raised");
		apb(1'h1, OFS_IRQMSK, 32'h0000_0000);
		chkb(irq, 1'h0, "irq masked");
		apb(1'h1, OFS_IRQST, 32'h0000_0004);
		rd_chk(OFS_IRQST, 32'h0000_0000, "irq cleared");
		unlockSes <= 2'h2;
		unlockValid <= 1'h1;
		tick(1);
		unlockValid <= 1'h0;
		rd_chk(OFS_LEVEL, 32'h0000_00C0, "session 2");
		lockReq <= 3'h4;
		tick(1);
		lockReq <= 3'h0;
		rd_chk(OFS_LEVEL, 32'h0000_0000, "locked");
	endtask

	task automatic t_menu;
		lsa_pol_t p;
		for (int i = 2; i >= 0; i--) begin
			p = lsa_pol_t'(i);
			resetPolicy <= p;
			bootHold <= 1'h1;
			sys_rst <= 1'h1;
			tick(8);
			sys_rst <= 1'h0;
			bootHold <= 1'h0;
			for (int n = 0; n < 60 && menuActive !== 1'h1; n++) begin
				tick(1);
			end
			chkb(menuActive, p != POL_OFF, "menu");
			chkb(passwordRestoreOption, p == POL_BOTH, "pw option");
			if (p != POL_OFF) begin
				pwConfirm <= 1'h1;
				tick(1);
				pwConfirm <= 1'h0;
				for (int n = 0; n < 5 && pwRestore !== 1'h1; n++) begin
					tick(1);
				end
				chkb(pwRestore, p == POL_BOTH, "pw restore");
			end
			if (p == POL_FACT_ONLY) begin
				apb(1'h1, OFS_CFG, M_ALL);
				factoryConfirm <= 1'h1;
				tick(1);
				factoryConfirm <= 1'h0;
				for (int n = 0; n < 5 && factoryReset !== 1'h1; n++) begin
					tick(1);
				end
				chkb(factoryReset, 1'h1, "factory");
				chkb(restartReq, 1'h1, "restart");
				tick(10);
				rd_chk(OFS_CFG, 32'h0000_0000, "soft clear");
			end
		end
	endtask

	// Watchdog against a hang
	initial begin
		#(25 * 40000);
		numErrors++;
		$display("MISMATCH %0t watchdog expired", $time);
		endSim();
	end

	// Main sequence
	initial begin
		tick(8);
		sys_rst <= 1'h0;
		tick(8);
		t_regs();
		t_ind();
		t_grp_coll();
		t_auto();
		t_remote();
		t_offdly();
		t_ses();
		t_menu();
		endSim();
	end
endmodule // test_latched_state_acknowledge
